// file: hdl/mttcu_defs.svh
// Purpose: Constants of the multimode timer/counter unit
// Assumes: APB byte addresses, 32-bit data
// Notes:   Included by the package and by the design files
`ifndef MTTCU_DEFS_SVH
`define MTTCU_DEFS_SVH

`define MTT_NUM_TMR       4
`define MTT_CNT_W         16
`define MTT_CFG_W         14
`define MTT_ADDR_W        8
`define MTT_PRE_W         11
`define MTT_EV_W          6

// Smallest counting periods in half-cycle time units, then CPU cycles
`define MTT_M1_MIN_HALF   16
`define MTT_M2_MIN_HALF   8
`define MTT_M1_MIN_CYC    (`MTT_M1_MIN_HALF / 2)
`define MTT_M2_MIN_CYC    (`MTT_M2_MIN_HALF / 2)

// Register map, byte offsets
`define MTT_CTRL_BASE     8'h00
`define MTT_CNT_BASE      8'h04
`define MTT_TMR_STRIDE    8'h10
`define MTT_OTL_ADDR      8'h40
`define MTT_STAT_ADDR     8'h44
`define MTT_MASK_ADDR     8'h48

// Reset values
`define MTT_CFG_RST       14'h0000
`define MTT_CNT_RST       16'h0000
`define MTT_OTL_RST       2'h0
`define MTT_EV_RST        6'h00

`endif

// file: hdl/mttcu_pkg.sv
// Purpose: Types of the multimode timer/counter unit
// Assumes: mttcu_defs.svh holds the numbers
// Notes:   Config struct layout equals the control register bits [13:0]
`include "mttcu_defs.svh"

package mttcu_pkg;

  typedef enum logic [1:0] {
    MTT_TIMER   = 2'b00,
    MTT_GATED   = 2'b01,
    MTT_COUNTER = 2'b10,
    MTT_QUAD    = 2'b11
  } mttcu_mode_t;

  typedef enum logic [1:0] {
    MTT_TRG_EXT  = 2'b00,
    MTT_TRG_RISE = 2'b01,
    MTT_TRG_FALL = 2'b10,
    MTT_TRG_ANY  = 2'b11
  } mttcu_trig_t;

  typedef struct packed {
    mttcu_trig_t rc_trig;
    logic        rc_cap;
    logic        rc_en;
    logic        chain;
    logic        pol;
    logic [2:0]  ps;
    logic        eud_en;
    logic        dir_down;
    logic        run;
    mttcu_mode_t mode;
  } mttcu_cfg_t;

  typedef struct packed {
    logic tick;
    logic edge_p;
    logic gate;
    logic chain;
    logic down;
  } mttcu_step_t;

endpackage

// file: hdl/mttcu_timer.sv
// Purpose: One up/down timer of the unit
// Assumes: Stimulus already synchronised and decoded by the parent
// Notes:   Wrap pulse is registered, one cycle after the wrapping step
`timescale 1ns/1ps
`include "mttcu_defs.svh"

module mttcu_timer #(
  parameter int unsigned WIDTH = `MTT_CNT_W
) (
  // Clock and reset
  input  wire logic                   sys_clk_i,
  input  wire logic                   reset_n_i,
  // Control
  input  wire mttcu_pkg::mttcu_cfg_t  cfg_i,
  input  wire mttcu_pkg::mttcu_step_t step_i,
  input  wire logic                   load_i,
  input  wire logic [WIDTH-1:0]       load_val_i,
  input  wire logic                   wr_i,
  input  wire logic [WIDTH-1:0]       wdata_i,
  // State
  output logic      [WIDTH-1:0]       count_o,
  output logic                        wrap_o
);
  import mttcu_pkg::*;

  localparam logic [WIDTH-1:0] ONE = {{(WIDTH-1){1'b0}}, 1'b1};

  if (WIDTH < 2 || WIDTH > 32) begin : g_chk
    $error("mttcu_timer: WIDTH must lie in 2..32");
  end

  logic [WIDTH-1:0] count_q, count_d;
  logic             wrap_q,  wrap_d;
  logic             step;

  always_comb begin
    unique case (cfg_i.mode)
      MTT_TIMER:   step = step_i.tick;
      MTT_GATED:   step = step_i.tick & step_i.gate;
      MTT_COUNTER: step = cfg_i.chain ? step_i.chain : step_i.edge_p;
      MTT_QUAD:    step = step_i.edge_p;
    endcase
    step    = step & cfg_i.run;
    count_d = count_q;
    wrap_d  = 1'b0;
    if (step) begin
      count_d = step_i.down ? count_q - ONE : count_q + ONE;
      wrap_d  = step_i.down ? (count_q == '0) : (count_q == '1);
    end
    if (load_i) begin
      count_d = load_val_i;
    end
    // Software write beats any hardware update in the same cycle
    if (wr_i) begin
      count_d = wdata_i;
    end
  end

  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      count_q <= `MTT_CNT_RST;
      wrap_q  <= 1'b0;
    end else begin
      count_q <= count_d;
      wrap_q  <= wrap_d;
    end
  end

  assign count_o = count_q;
  assign wrap_o  = wrap_q;

endmodule // mttcu_timer

// file: hdl/mttcu_top.sv
// Purpose: Multimode timer/counter unit, two modules of core plus aux timer
// Assumes: APB slave, 50 MHz sys_clk_i, pins asynchronous to sys_clk_i
// Notes:   Timer 0/1 = first module core/aux, 2/3 = second module core/aux
//
// Added by the designer: the APB interface to the registers and the register offsets.
`timescale 1ns/1ps
`include "mttcu_defs.svh"

module mttcu_top #(
  parameter int unsigned PRE_W = `MTT_PRE_W
) (
  // Clock and reset
  input  wire logic                    sys_clk_i,
  input  wire logic                    reset_n_i,
  // APB slave
  input  wire logic                    psel,
  input  wire logic                    penable,
  input  wire logic                    pwrite,
  input  wire logic [`MTT_ADDR_W-1:0]  paddr,
  input  wire logic [31:0]             pwdata,
  output logic      [31:0]             prdata,
  output logic                         pready,
  output logic                         pslverr,
  // Pins, one per timer
  input  wire logic [`MTT_NUM_TMR-1:0] external_count_input_i,
  input  wire logic [`MTT_NUM_TMR-1:0] external_direction_input_i,
  // Outputs
  output logic      [1:0]              core_toggle_latch_o,
  output logic                         irq_o
);
  import mttcu_pkg::*;

  localparam int unsigned NT = `MTT_NUM_TMR;
  localparam int unsigned CW = `MTT_CNT_W;

  // Largest prescaled period is 8 << 7 cycles
  if (PRE_W < 11 || PRE_W > 31) begin : g_chk
    $error("mttcu_top: PRE_W must lie in 11..31");
  end

  // Struct layout must match the CTRL field width
  if ($bits(mttcu_cfg_t) != `MTT_CFG_W) begin : g_cfg_chk
    $error("mttcu_top: config struct width differs from MTT_CFG_W");
  end

  // Timers pair as core and aux, one latch per pair
  if (NT % 2 != 0 || NT / 2 != $bits(core_toggle_latch_o)) begin : g_nt_chk
    $error("mttcu_top: timer count must be twice the latch count");
  end

  // One status bit per timer wrap and per module trigger
  if (`MTT_EV_W != NT + $bits(core_toggle_latch_o)) begin : g_ev_chk
    $error("mttcu_top: event width does not match timer count");
  end

  // Tick on the last count of each period, so all timers stay aligned
  function automatic logic pre_tick(input logic [PRE_W-1:0] cnt,
                                    input logic [PRE_W-1:0] base,
                                    input logic [2:0]       ps);
    logic [PRE_W-1:0] mask;
    mask     = (base << ps) - {{(PRE_W-1){1'b0}}, 1'b1};
    pre_tick = (cnt & mask) == mask;
  endfunction

  // Byte address of a per-timer register
  function automatic logic [`MTT_ADDR_W-1:0] tmr_addr(input int unsigned i,
                                                      input logic [`MTT_ADDR_W-1:0] base);
    tmr_addr = base + `MTT_ADDR_W'(i * `MTT_TMR_STRIDE);
  endfunction

  // Pin synchronisers; stage 3 serves edge detection and quadrature direction
  logic [2*NT-1:0] pin_s1_q, pin_s2_q, pin_s3_q;
  logic [2*NT-1:0] pin_s1_d, pin_s2_d, pin_s3_d;
  logic [NT-1:0]   a_now, a_old, b_now, b_old;

  always_comb begin
    pin_s1_d = {external_direction_input_i, external_count_input_i};
    pin_s2_d = pin_s1_q;
    pin_s3_d = pin_s2_q;
    a_now    = pin_s2_q[NT-1:0];
    a_old    = pin_s3_q[NT-1:0];
    b_now    = pin_s2_q[2*NT-1:NT];
    b_old    = pin_s3_q[2*NT-1:NT];
  end

  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      pin_s1_q <= '0;
      pin_s2_q <= '0;
      pin_s3_q <= '0;
    end else begin
      pin_s1_q <= pin_s1_d;
      pin_s2_q <= pin_s2_d;
      pin_s3_q <= pin_s3_d;
    end
  end

  // Shared free-running prescaler
  logic [PRE_W-1:0] pre_q, pre_d;

  always_comb begin
    pre_d = pre_q + {{(PRE_W-1){1'b0}}, 1'b1};
  end

  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      pre_q <= '0;
    end else begin
      pre_q <= pre_d;
    end
  end

  // Software state
  mttcu_cfg_t              cfg_q   [NT];
  mttcu_cfg_t              cfg_d   [NT];
  logic [1:0]              otl_q,  otl_d, otl_prev_q;
  logic [`MTT_EV_W-1:0]    stat_q, stat_d, mask_q, mask_d;
  logic [31:0]             rdata_q, rdata_d;

  // Timer wiring
  mttcu_step_t             step    [NT];
  logic [NT-1:0]           load, wr_cnt, wrap;
  logic [CW-1:0]           load_val [NT];
  logic [CW-1:0]           count    [NT];
  logic [1:0]              otl_chg, otl_rise, otl_fall, rc_fire;
  logic [NT-1:0]           ext_edge;

  logic                    setup, wr_acc, hit;
  logic [`MTT_ADDR_W-1:0]  addr;

  assign setup  = psel & ~penable;
  assign wr_acc = psel & penable & pwrite;
  assign addr   = paddr;

  always_comb begin
    otl_chg  = otl_q ^ otl_prev_q;
    otl_rise = otl_q & ~otl_prev_q;
    otl_fall = ~otl_q & otl_prev_q;
    for (int i = 0; i < NT; i++) begin
      ext_edge[i] = cfg_q[i].pol ? (a_old[i] & ~a_now[i]) : (a_now[i] & ~a_old[i]);
      step[i].tick  = (i < 2) ? pre_tick(pre_q, PRE_W'(`MTT_M1_MIN_CYC), cfg_q[i].ps)
                              : pre_tick(pre_q, PRE_W'(`MTT_M2_MIN_CYC), cfg_q[i].ps);
      step[i].gate  = a_now[i] ^ cfg_q[i].pol;
      step[i].chain = (i % 2 == 1) ? otl_chg[i/2] : 1'b0;
      if (cfg_q[i].mode == MTT_QUAD) begin
        // Phase A leads B when counting up
        // Direction compares A now with B one sample back
        step[i].edge_p = (a_now[i] ^ a_old[i]) | (b_now[i] ^ b_old[i]);
        step[i].down   = cfg_q[i].dir_down ^ ~(a_now[i] ^ b_old[i]);
      end else begin
        step[i].edge_p = ext_edge[i];
        step[i].down   = cfg_q[i].dir_down ^ (cfg_q[i].eud_en & b_now[i]);
      end
    end
  end

  // Reload or capture, configured in each module's aux control
  // Capture copies core into aux, reload copies aux into core
  always_comb begin
    load = '0;
    for (int m = 0; m < 2; m++) begin
      unique case (cfg_q[2*m+1].rc_trig)
        MTT_TRG_EXT:  rc_fire[m] = ext_edge[2*m+1];
        MTT_TRG_RISE: rc_fire[m] = otl_rise[m];
        MTT_TRG_FALL: rc_fire[m] = otl_fall[m];
        MTT_TRG_ANY:  rc_fire[m] = otl_chg[m];
      endcase
      rc_fire[m] = rc_fire[m] & cfg_q[2*m+1].rc_en;
      if (cfg_q[2*m+1].rc_cap) begin
        load[2*m+1] = rc_fire[m];
      end else begin
        load[2*m]   = rc_fire[m];
      end
      load_val[2*m]   = count[2*m+1];
      load_val[2*m+1] = count[2*m];
    end
  end

  for (genvar g = 0; g < NT; g++) begin : g_tmr
    assign wr_cnt[g] = wr_acc & (addr == tmr_addr(g, `MTT_CNT_BASE));
    mttcu_timer #(
      .WIDTH      (CW)
    ) mttcu_timer_inst (
      .sys_clk_i  (sys_clk_i),
      .reset_n_i  (reset_n_i),
      .cfg_i      (cfg_q[g]),
      .step_i     (step[g]),
      .load_i     (load[g]),
      .load_val_i (load_val[g]),
      .wr_i       (wr_cnt[g]),
      .wdata_i    (pwdata[CW-1:0]),
      .count_o    (count[g]),
      .wrap_o     (wrap[g])
    );
  end

  // Register writes, toggle latches and events
  always_comb begin
    for (int i = 0; i < NT; i++) begin
      cfg_d[i] = cfg_q[i];
      if (wr_acc && addr == tmr_addr(i, `MTT_CTRL_BASE)) begin
        cfg_d[i] = mttcu_cfg_t'(pwdata[`MTT_CFG_W-1:0]);
        // Quadrature exists only in the first module
        if (i >= 2 && cfg_d[i].mode == MTT_QUAD) begin
          cfg_d[i].mode = MTT_COUNTER;
        end
      end
    end
    otl_d = otl_q ^ {wrap[2], wrap[0]};
    if (wr_acc && addr == `MTT_OTL_ADDR) begin
      otl_d = pwdata[1:0];
    end
  end

  // Sticky events; a new event wins over a clear in the same cycle
  always_comb begin
    mask_d = mask_q;
    if (wr_acc && addr == `MTT_MASK_ADDR) begin
      mask_d = pwdata[`MTT_EV_W-1:0];
    end
    stat_d = stat_q;
    if (wr_acc && addr == `MTT_STAT_ADDR) begin
      stat_d = stat_q & ~pwdata[`MTT_EV_W-1:0];
    end
    stat_d = stat_d | {rc_fire, wrap};
  end

  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      stat_q <= `MTT_EV_RST;
      mask_q <= `MTT_EV_RST;
    end else begin
      stat_q <= stat_d;
      mask_q <= mask_d;
    end
  end

  // Read data captured in the setup cycle, answered in the access cycle
  always_comb begin
    hit     = 1'b0;
    rdata_d = rdata_q;
    for (int i = 0; i < NT; i++) begin
      if (addr == tmr_addr(i, `MTT_CTRL_BASE)) begin
        hit     = 1'b1;
        rdata_d = {{(32-`MTT_CFG_W){1'b0}}, cfg_q[i]};
      end
      if (addr == tmr_addr(i, `MTT_CNT_BASE)) begin
        hit     = 1'b1;
        rdata_d = {{(32-CW){1'b0}}, count[i]};
      end
    end
    if (addr == `MTT_OTL_ADDR) begin
      hit     = 1'b1;
      rdata_d = {30'h0000_0000, otl_q};
    end
    if (addr == `MTT_STAT_ADDR) begin
      hit     = 1'b1;
      rdata_d = {{(32-`MTT_EV_W){1'b0}}, stat_q};
    end
    if (addr == `MTT_MASK_ADDR) begin
      hit     = 1'b1;
      rdata_d = {{(32-`MTT_EV_W){1'b0}}, mask_q};
    end
    if (setup && !hit) begin
      rdata_d = 32'h0000_0000;
    end
    if (!setup) begin
      rdata_d = rdata_q;
    end
  end

  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      for (int i = 0; i < NT; i++) begin
        cfg_q[i] <= mttcu_cfg_t'(`MTT_CFG_RST);
      end
      otl_q      <= `MTT_OTL_RST;
      otl_prev_q <= `MTT_OTL_RST;
      rdata_q    <= 32'h0000_0000;
    end else begin
      for (int i = 0; i < NT; i++) begin
        cfg_q[i] <= cfg_d[i];
      end
      otl_q      <= otl_d;
      otl_prev_q <= otl_q;
      rdata_q    <= rdata_d;
    end
  end

  assign prdata              = rdata_q;
  // Read data is ready from the setup edge, so no wait states
  assign pready              = 1'b1;
  assign pslverr             = psel & penable & ~hit;
  assign core_toggle_latch_o = otl_q;
  assign irq_o               = |(stat_q & mask_q);

endmodule // mttcu_top

// file: bench/mttcu_monitor.sv
// Purpose: Port checker of the timer unit
// Assumes: Sees only the mttcu_top ports
// Notes:   Bound below, one clock domain
`timescale 1ns/1ps
`include "mttcu_defs.svh"
module mttcu_monitor (
  // Clock and reset
  input wire logic                   sys_clk_i,
  input wire logic                   reset_n_i,
  // APB
  input wire logic                   psel,
  input wire logic                   penable,
  input wire logic                   pwrite,
  input wire logic [`MTT_ADDR_W-1:0] paddr,
  input wire logic [31:0]            pwdata,
  input wire logic [31:0]            prdata,
  input wire logic                   pready,
  input wire logic                   pslverr,
  // Outputs
  input wire logic [1:0]             core_toggle_latch_o,
  input wire logic                   irq_o
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!reset_n_i);
  logic acc;
  logic map;
  logic otl_wr_d;
  logic otl_wr_q;
  assign acc = psel && penable;
  assign map = paddr[1:0] == 2'h0 && (paddr < `MTT_OTL_ADDR ? !paddr[3] : paddr <= `MTT_MASK_ADDR);
  assign otl_wr_d = acc && pwrite && paddr == `MTT_OTL_ADDR;
  // A software latch write is exempt from the step rate limit
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      otl_wr_q <= 1'b0;
    end else begin
      otl_wr_q <= otl_wr_d;
    end
  end
  property p_reset;
    $rose(reset_n_i) |-> core_toggle_latch_o == 2'h0 && !irq_o && prdata == 32'h0;
  endproperty
  a_reset: assert property (p_reset) else $error("state after reset not clear");
  property p_ready;
    pready;
  endproperty
  a_ready: assert property (p_ready) else $error("pready low");
  property p_err;
    acc |-> pslverr == !map;
  endproperty
  a_err: assert property (p_err) else $error("pslverr does not match address");
  property p_err_idle;
    !acc |-> !pslverr;
  endproperty
  a_err_idle: assert property (p_err_idle) else $error("pslverr outside access");
  property p_bad_rd;
    acc && !pwrite && !map |-> prdata == 32'h0;
  endproperty
  a_bad_rd: assert property (p_bad_rd) else $error("unmapped read not zero");
  property p_rd_hold;
    acc && !pwrite |=> $stable(prdata);
  endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
  property p_otl_wr;
    otl_wr_d |=> {30'h0, core_toggle_latch_o} == ($past(pwdata) & 32'h3);
  endproperty
  a_otl_wr: assert property (p_otl_wr) else $error("latch write lost");
  property p_m1_rate;
    $changed(core_toggle_latch_o[0]) && !otl_wr_q |=>
      ($stable(core_toggle_latch_o[0]) || otl_wr_q) [*7];
  endproperty
  a_m1_rate: assert property (p_m1_rate) else $error("first latch too fast");
  property p_m2_rate;
    $changed(core_toggle_latch_o[1]) && !otl_wr_q |=>
      ($stable(core_toggle_latch_o[1]) || otl_wr_q) [*3];
  endproperty
  a_m2_rate: assert property (p_m2_rate) else $error("second latch too fast");
  property p_mask;
    acc && pwrite && paddr == `MTT_MASK_ADDR && pwdata[5:0] == 6'h0 |=> !irq_o;
  endproperty
  a_mask: assert property (p_mask) else $error("masked interrupt still high");
  c_otl: cover property (otl_wr_d);
  c_irq: cover property ($rose(irq_o));
  c_err: cover property (acc && pslverr);
endmodule // mttcu_monitor

bind mttcu_top mttcu_monitor mttcu_monitor_inst (
  .sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .core_toggle_latch_o(core_toggle_latch_o), .irq_o(irq_o)
);

// file: bench/mttcu_pins.sv
// Purpose: External count, gate and sensor pins
// Assumes: Levels held far longer than the two-flop sampler needs
// Notes:   Tasks called by the bench
`timescale 1ns/1ps
module mttcu_pins (
  // Clock
  input  wire logic       sys_clk_i,
  // Pins
  output logic      [3:0] cnt_o,
  output logic      [3:0] dir_o
);
  initial begin
    cnt_o = 4'h0;
    dir_o = 4'h0;
  end
  task automatic flip(input bit b, input int i);
    @(posedge sys_clk_i);
    if (b) dir_o[i] <= ~dir_o[i];
    else cnt_o[i] <= ~cnt_o[i];
    repeat (10) @(posedge sys_clk_i);
  endtask
  task automatic pulse(input int i);
    flip(1'b0, i);
    flip(1'b0, i);
  endtask
  // Gray sequence, phase A leads when moving forward
  task automatic quad(input bit fwd, input int n);
    repeat (n) begin
      flip(~fwd, 0);
      flip(fwd, 0);
      flip(~fwd, 0);
      flip(fwd, 0);
    end
  endtask
endmodule // mttcu_pins

// file: bench/mttcu_top_tb.sv
// Purpose: Self-checking bench of the timer unit
// Assumes: Pin model drives the external inputs
// Notes:   Rate windows are exact multiples of the step period
`timescale 1ns/1ps
`include "mttcu_defs.svh"
`define CHK(n, e, s) begin check_count++; if ((s) !== (e)) begin error_cnt++; \
  $display("wrong value %s exp %0h got %0h", n, e, s); end end
module mttcu_top_tb;
  import mttcu_pkg::*;
  logic        sys_clk_i = 1'b0;
  logic        reset_n_i = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic [31:0] rd;
  logic        pready;
  logic        pslverr;
  logic        err;
  logic [3:0]  cnt_pin;
  logic [3:0]  dir_pin;
  logic [1:0]  otl;
  logic        irq;
  logic [15:0] v;
  logic        dn;
  int          error_cnt = 0;
  int          check_count = 0;
  int          p;
  int          k;
  mttcu_cfg_t  c;
  always #10 sys_clk_i = ~sys_clk_i;
  mttcu_top mttcu_top_inst (.sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .external_count_input_i(cnt_pin),
    .external_direction_input_i(dir_pin), .core_toggle_latch_o(otl), .irq_o(irq));
  mttcu_pins mttcu_pins_inst (.sys_clk_i(sys_clk_i), .cnt_o(cnt_pin), .dir_o(dir_pin));
  task automatic finish_test();
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk_i);
    penable <= 1'b1;
    do begin
      @(posedge sys_clk_i);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      error_cnt++;
      finish_test();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge sys_clk_i);
  endtask
  function automatic logic [7:0] ra(input int i, input bit n);
    return 8'(i) * `MTT_TMR_STRIDE + (n ? `MTT_CNT_BASE : `MTT_CTRL_BASE);
  endfunction
  task automatic wrc(input int i);
    apb(1'b1, ra(i, 1'b0), {18'h0, c});
  endtask
  task automatic rdc(input int i);
    apb(1'b0, ra(i, 1'b1), 32'h0);
  endtask
  initial begin
    repeat (90000) @(posedge sys_clk_i);
    error_cnt++;
    finish_test();
  end
  initial begin
    void'($urandom(32'h81EF));
    repeat (6) @(posedge sys_clk_i);
    reset_n_i <= 1'b1;
    @(posedge sys_clk_i);
    for (int i = 0; i < 4; i++) begin
      apb(1'b0, ra(i, 1'b0), 32'h0); `CHK("ctrl", 32'h0, rd)
      rdc(i); `CHK("count", 32'h0, rd)
    end
    apb(1'b0, `MTT_OTL_ADDR, 32'h0); `CHK("latches", 32'h0, rd)
    apb(1'b0, 8'h4C, 32'h0); `CHK("slverr", 1'b1, err)
    c = '0;
    c.mode = MTT_QUAD;
    wrc(2);
    apb(1'b0, ra(2, 1'b0), 32'h0); `CHK("mode", 2'b10, rd[1:0])
    mttcu_pins_inst.flip(1'b1, 2);
    for (int t = 0; t < 8; t++) begin
      int i;
      i = t % 4;
      c = '0;
      c.run = 1'b1;
      c.ps = 3'($urandom_range(2));
      c.dir_down = 1'($urandom);
      c.eud_en = 1'($urandom);
      apb(1'b1, ra(i, 1'b1), 32'($urandom & 32'hFFFF));
      wrc(i);
      k = 3;
      p = (i < 2 ? `MTT_M1_MIN_CYC : `MTT_M2_MIN_CYC) << c.ps;
      rdc(i);
      v = rd[15:0];
      // Read spacing equals k step periods
      repeat (k * p - 3) @(posedge sys_clk_i);
      rdc(i);
      dn = c.dir_down ^ (c.eud_en & dir_pin[i]);
      `CHK("rate", dn ? v - 16'(k) : v + 16'(k), rd[15:0])
      c.run = 1'b0;
      wrc(i);
    end
    apb(1'b1, `MTT_OTL_ADDR, 32'h0);
    apb(1'b1, `MTT_STAT_ADDR, 32'h3F);
    apb(1'b1, `MTT_MASK_ADDR, 32'h5);
    for (int i = 0; i < 4; i += 2) begin
      apb(1'b1, ra(i, 1'b1), 32'hFFFF);
      c = '0;
      c.run = 1'b1;
      wrc(i);
      repeat (20) @(posedge sys_clk_i);
      `CHK("latch", 1'b1, otl[i/2])
      `CHK("irq", 1'b1, irq)
      c.run = 1'b0;
      c.ps = 3'h7;
      wrc(i);
      `CHK("latch kept", 1'b1, otl[i/2])
      apb(1'b0, `MTT_STAT_ADDR, 32'h0); `CHK("status", 32'h1 << i, rd)
      apb(1'b1, `MTT_MASK_ADDR, 32'h0); `CHK("masked", 1'b0, irq)
      apb(1'b1, `MTT_MASK_ADDR, 32'h5);
      apb(1'b1, `MTT_STAT_ADDR, 32'h1 << i); `CHK("cleared", 1'b0, irq)
    end
    c = '0;
    c.mode = MTT_COUNTER;
    c.run = 1'b1;
    c.pol = 1'($urandom);
    apb(1'b1, ra(1, 1'b1), 32'h0);
    wrc(1);
    k = 1 + $urandom_range(4);
    repeat (k) mttcu_pins_inst.pulse(1);
    rdc(1); `CHK("events", 32'(k), rd)
    c = '0;
    c.mode = MTT_GATED;
    c.run = 1'b1;
    apb(1'b1, ra(3, 1'b1), 32'h0);
    wrc(3);
    repeat (40) @(posedge sys_clk_i);
    rdc(3); `CHK("gate shut", 32'h0, rd)
    mttcu_pins_inst.flip(1'b0, 3);
    rdc(3); `CHK("gate open", 1'b1, rd != 32'h0)
    c = '0;
    c.mode = MTT_QUAD;
    c.run = 1'b1;
    apb(1'b1, ra(0, 1'b1), 32'h10);
    wrc(0);
    mttcu_pins_inst.quad(1'b1, 3);
    mttcu_pins_inst.quad(1'b0, 1);
    rdc(0); `CHK("position", 32'h18, rd)
    c = '0;
    c.mode = MTT_COUNTER;
    c.chain = 1'b1;
    c.run = 1'b1;
    apb(1'b1, ra(1, 1'b1), 32'h0);
    wrc(1);
    apb(1'b1, ra(0, 1'b1), 32'hFFFF);
    c = '0;
    c.run = 1'b1;
    wrc(0);
    repeat (20) @(posedge sys_clk_i);
    rdc(1); `CHK("chained", 32'h1, rd)
    c.run = 1'b0;
    wrc(0);
    apb(1'b1, ra(0, 1'b1), 32'h1234);
    c = '0;
    c.rc_en = 1'b1;
    c.rc_cap = 1'b1;
    c.rc_trig = MTT_TRG_EXT;
    wrc(1);
    mttcu_pins_inst.pulse(1);
    rdc(1); `CHK("capture", 32'h1234, rd)
    apb(1'b1, ra(1, 1'b1), 32'hABC);
    c.rc_cap = 1'b0;
    wrc(1);
    mttcu_pins_inst.pulse(1);
    rdc(0); `CHK("reload", 32'hABC, rd)
    apb(1'b0, `MTT_STAT_ADDR, 32'h0); `CHK("fired", 1'b1, rd[4])
    apb(1'b1, `MTT_OTL_ADDR, 32'h0);
    apb(1'b1, ra(2, 1'b1), 32'h55);
    c = '0;
    c.rc_en = 1'b1;
    c.rc_cap = 1'b1;
    c.rc_trig = MTT_TRG_RISE;
    wrc(3);
    apb(1'b1, `MTT_OTL_ADDR, 32'h2);
    rdc(3); `CHK("latch rise", 32'h55, rd)
    apb(1'b1, ra(2, 1'b1), 32'h66);
    apb(1'b1, `MTT_OTL_ADDR, 32'h0);
    rdc(3); `CHK("latch fall", 32'h55, rd)
    finish_test();
  end
endmodule // mttcu_top_tb
